// ==== hdl/charge_pkg.sv ====
// constants shared by the charge supervisor design
package charge_pkg;

  // ==========================================================
  // clock and timebase
  localparam int unsigned CLK_HZ          = 25_000_000;
  localparam int unsigned FLASH_HZ        = 1;
  // half period of the 1 Hz, 50% duty flash pattern in clk_sys cycles
  localparam int unsigned FLASH_HALF_CYC  = CLK_HZ / (FLASH_HZ * 2);
  localparam int unsigned TICK_HZ         = 1;
  localparam int unsigned TICK_CYC        = CLK_HZ / TICK_HZ;

  // ==========================================================
  // safety timer periods in seconds
  localparam int unsigned PRECON_S        = 3600;
  localparam int unsigned FAST_S          = 5400;
  localparam int unsigned TERM_S          = 10800;

  // ==========================================================
  // apb register map (byte addresses)
  localparam logic [7:0] ADDR_CTRL        = 8'h00;
  localparam logic [7:0] ADDR_STATUS      = 8'h04;
  localparam logic [7:0] ADDR_IRQ_STAT    = 8'h08;
  localparam logic [7:0] ADDR_IRQ_MASK    = 8'h0C;

  // ctrl fields
  localparam int unsigned CTRL_ENABLE_BIT = 0;
  localparam int unsigned CTRL_VSEL_BIT   = 1;
  localparam logic [1:0]  CTRL_RESET_VAL  = 2'h1;

  // irq fields
  localparam int unsigned IRQ_W           = 4;
  localparam int unsigned IRQ_DONE_BIT    = 0;
  localparam int unsigned IRQ_FAULT_BIT   = 1;
  localparam int unsigned IRQ_TEMP_BIT    = 2;
  localparam int unsigned IRQ_PHASE_BIT   = 3;
  localparam logic [3:0]  IRQ_MASK_RESET  = 4'h0;

  // ==========================================================
  // charge phases
  typedef enum logic [2:0] {
    PH_OFF,
    PH_QUAL,
    PH_PRECON,
    PH_CC,
    PH_CV,
    PH_DONE,
    PH_FAULT
  } phase_e;

endpackage

// ==== hdl/safety_timer.sv ====
// one-second-tick safety timer with clear and expiry flag
`timescale 1ns/10ps
module safety_timer (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // control
  input  wire logic        tick,
  input  wire logic        run,
  input  wire logic        clear,
  input  wire logic [15:0] limit,
  // status
  output logic             expired
);

  logic [15:0] count_reg;
  logic [15:0] count_next;

  // clear wins; count only on ticks while running, saturate at limit
  assign count_next = clear ? 16'h0000 :
                      (run && tick && (count_reg != limit)) ? count_reg + 16'h0001 :
                      count_reg;

  // counter state
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      count_reg <= 16'h0000;
    end else begin
      count_reg <= count_next;
    end
  end

  assign expired = (count_reg == limit) && !clear;

endmodule

// ==== hdl/charge_state_supervisor.sv ====
// charge sequencer with status outputs, safety timers and apb registers
// Function
// - condition output on when powered, enabled, normal
// - fault: charge output off, condition flashes
// - fault latched until supply or enable cycle
// - temperature invalid holds or suspends charge
// - charge resumes automatically once temperature valid
// - select low 4.1V, high 4.2V; the CTRL vsel bit, when set, forces vreg_high even with select low
// - enable low disables and terminates charge
// - enable rising edge starts new cycle
// - undervoltage halts all charging, low power
// - precondition, then constant current, then voltage
// - charge output on while charging, flashes done
// - precondition timer from qualification; expiry ends charge
//
// Local design decisions: the address map and the APB slave port.
`timescale 1ns/10ps
module charge_state_supervisor (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // supply and control pins
  input  wire logic        supply_ok,
  input  wire logic        enable_in,
  input  wire logic        regulation_voltage_select,
  // analog comparator results
  input  wire logic        cell_temp_sense_in,
  input  wire logic        cell_above_precon,
  input  wire logic        cell_at_regulation,
  input  wire logic        current_below_term,
  input  wire logic        cell_fault_in,
  // regulation loop controls
  output logic             charge_on,
  output logic             precon_mode,
  output logic             cv_mode,
  output logic             vreg_high,
  output logic             low_power,
  // open-drain status pins
  input  wire logic        charge_indicator_in,
  output logic             charge_indicator_out,
  output logic             charge_indicator_oe,
  input  wire logic        condition_indicator_in,
  output logic             condition_indicator_out,
  output logic             condition_indicator_oe,
  // interrupt
  output logic             irq
);

  // ==========================================================
  // enable logic and edge detection

  logic        sw_en_reg;
  logic        sw_vsel_reg;
  logic        en_reg;
  logic        powered_reg;
  logic        en_all;
  logic        en_rise;
  logic        supply_rise;
  logic        restart;

  // enabled only when pin, software enable and supply all agree
  assign en_all      = enable_in && sw_en_reg && supply_ok;
  assign en_rise     = en_all && !en_reg;
  assign supply_rise = supply_ok && !powered_reg;
  assign restart     = en_rise || supply_rise;

  // previous levels for edge detection
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      en_reg      <= 1'b0;
      powered_reg <= 1'b0;
    end else begin
      en_reg      <= en_all;
      powered_reg <= supply_ok;
    end
  end

  // ==========================================================
  // timebase: one-second tick and flash phase

  logic [24:0] tick_cnt_reg;
  logic [24:0] flash_cnt_reg;
  logic        flash_reg;
  logic        tick;
  logic        flash_wrap;

  // terminal count of a divider that wraps every period cycles
  function automatic int unsigned last_count(input int unsigned period);
    return period - 1;
  endfunction

  assign tick       = (tick_cnt_reg == 25'(last_count(charge_pkg::TICK_CYC)));
  assign flash_wrap = (flash_cnt_reg == 25'(last_count(charge_pkg::FLASH_HALF_CYC)));

  // flash phase toggles only on clock edges so it cannot glitch
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tick_cnt_reg  <= 25'h0000000;
      flash_cnt_reg <= 25'h0000000;
      flash_reg     <= 1'b0;
    end else begin
      tick_cnt_reg  <= tick ? 25'h0000000 : tick_cnt_reg + 25'h0000001;
      flash_cnt_reg <= flash_wrap ? 25'h0000000 : flash_cnt_reg + 25'h0000001;
      if (flash_wrap) begin
        flash_reg <= !flash_reg;
      end
    end
  end

  // ==========================================================
  // phase machine

  charge_pkg::phase_e phase_reg;
  charge_pkg::phase_e phase_next;
  logic               temp_ok;
  logic               pre_exp;
  logic               fast_exp;
  logic               term_exp;
  logic               clr_pre;
  logic               clr_fast;
  logic               clr_term;

  // outside window just pauses; timers hold their count meanwhile
  assign temp_ok = cell_temp_sense_in;

  // next phase selection
  always_comb begin
    phase_next = phase_reg;
    if (!supply_ok || !en_all) begin
      phase_next = charge_pkg::PH_OFF;
    end else if (restart) begin
      phase_next = charge_pkg::PH_QUAL;
    end else begin
      case (phase_reg)
        charge_pkg::PH_OFF: begin
          phase_next = charge_pkg::PH_QUAL;
        end
        charge_pkg::PH_QUAL: begin
          if (cell_fault_in) begin
            phase_next = charge_pkg::PH_FAULT;
          end else if (temp_ok) begin
            phase_next = charge_pkg::PH_PRECON;
          end
        end
        charge_pkg::PH_PRECON: begin
          if (pre_exp || cell_fault_in) begin
            phase_next = charge_pkg::PH_FAULT;
          end else if (temp_ok && cell_above_precon) begin
            phase_next = charge_pkg::PH_CC;
          end
        end
        charge_pkg::PH_CC: begin
          if (fast_exp || term_exp || cell_fault_in) begin
            phase_next = charge_pkg::PH_FAULT;
          end else if (temp_ok && cell_at_regulation) begin
            phase_next = charge_pkg::PH_CV;
          end
        end
        charge_pkg::PH_CV: begin
          if (term_exp || (temp_ok && current_below_term)) begin
            phase_next = charge_pkg::PH_DONE;
          end else if (cell_fault_in) begin
            phase_next = charge_pkg::PH_FAULT;
          end
        end
        charge_pkg::PH_DONE: begin
          phase_next = charge_pkg::PH_DONE;
        end
        charge_pkg::PH_FAULT: begin
          phase_next = charge_pkg::PH_FAULT;
        end
        default: begin
          phase_next = charge_pkg::PH_OFF;
        end
      endcase
    end
  end

  // phase register
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      phase_reg <= charge_pkg::PH_OFF;
    end else begin
      phase_reg <= phase_next;
    end
  end

  // ==========================================================
  // safety timers: count only while charging and temperature valid

  logic in_pre;
  logic in_fast;
  logic in_charge;

  assign in_pre    = (phase_reg == charge_pkg::PH_PRECON);
  assign in_fast   = (phase_reg == charge_pkg::PH_CC);
  assign in_charge = in_fast || (phase_reg == charge_pkg::PH_CV);
  assign clr_pre   = !in_pre;
  assign clr_fast  = !in_fast;
  assign clr_term  = !in_charge;

  safety_timer u_pre (
    .clk_sys (clk_sys),
    .rst     (rst),
    .tick    (tick),
    .run     (temp_ok),
    .clear   (clr_pre),
    .limit   (16'(charge_pkg::PRECON_S)),
    .expired (pre_exp)
  );

  safety_timer u_fast (
    .clk_sys (clk_sys),
    .rst     (rst),
    .tick    (tick),
    .run     (temp_ok),
    .clear   (clr_fast),
    .limit   (16'(charge_pkg::FAST_S)),
    .expired (fast_exp)
  );

  safety_timer u_term (
    .clk_sys (clk_sys),
    .rst     (rst),
    .tick    (tick),
    .run     (temp_ok),
    .clear   (clr_term),
    .limit   (16'(charge_pkg::TERM_S)),
    .expired (term_exp)
  );

  // ==========================================================
  // regulation controls and status pins

  logic charging;
  logic is_fault;
  logic is_done;
  logic charge_indicator_out_on;
  logic condition_indicator_out_on;
  logic charge_indicator_out_reg;
  logic condition_indicator_out_reg;
  logic ctl_on_reg;
  logic ctl_pre_reg;
  logic ctl_cv_reg;
  logic vreg_reg;

  assign charging = (phase_reg == charge_pkg::PH_PRECON) || in_charge;
  assign is_fault = (phase_reg == charge_pkg::PH_FAULT);
  assign is_done  = (phase_reg == charge_pkg::PH_DONE);
  // charge output: on while charging and temp valid, flashes when done
  assign charge_indicator_out_on = (charging && temp_ok) || (is_done && flash_reg);
  // condition output: steady when normal, flashes on fault or bad temp;
  // bad temp counts in qualification too, since it blocks the start
  assign condition_indicator_out_on = (is_fault || (en_all && !temp_ok)) ? flash_reg :
                    (supply_ok && en_all);

  // outputs registered except low_power; halt everything below undervoltage
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      charge_indicator_out_reg   <= 1'b0;
      condition_indicator_out_reg   <= 1'b0;
      ctl_on_reg  <= 1'b0;
      ctl_pre_reg <= 1'b0;
      ctl_cv_reg  <= 1'b0;
      vreg_reg    <= 1'b0;
    end else begin
      charge_indicator_out_reg   <= charge_indicator_out_on;
      condition_indicator_out_reg   <= condition_indicator_out_on;
      ctl_on_reg  <= charging && temp_ok && supply_ok && en_all;
      ctl_pre_reg <= in_pre;
      ctl_cv_reg  <= (phase_reg == charge_pkg::PH_CV);
      vreg_reg    <= regulation_voltage_select || sw_vsel_reg;
    end
  end

  assign charge_on               = ctl_on_reg;
  assign precon_mode             = ctl_pre_reg;
  assign cv_mode                 = ctl_cv_reg;
  assign vreg_high               = vreg_reg;
  assign low_power               = !supply_ok || !en_all;
  // open drain: pin pulled low while on, released otherwise
  assign charge_indicator_out    = 1'b0;
  assign charge_indicator_oe     = charge_indicator_out_reg;
  assign condition_indicator_out = 1'b0;
  assign condition_indicator_oe  = condition_indicator_out_reg;

  // ==========================================================
  // interrupts

  logic [3:0] irq_stat_reg;
  logic [3:0] irq_mask_reg;
  logic [3:0] irq_evt;
  logic [3:0] irq_clr;
  logic       temp_bad_reg;

  assign irq_evt[charge_pkg::IRQ_DONE_BIT]  = !is_done && (phase_next == charge_pkg::PH_DONE);
  assign irq_evt[charge_pkg::IRQ_FAULT_BIT] = !is_fault && (phase_next == charge_pkg::PH_FAULT);
  assign irq_evt[charge_pkg::IRQ_TEMP_BIT]  = !temp_ok && !temp_bad_reg;
  assign irq_evt[charge_pkg::IRQ_PHASE_BIT] = (phase_next != phase_reg);
  assign irq = |(irq_stat_reg & irq_mask_reg);

  // ==========================================================
  // apb slave, zero wait states

  logic apb_wr;
  logic hit;

  assign apb_wr  = psel && penable && pwrite;
  assign hit     = (paddr == charge_pkg::ADDR_CTRL) || (paddr == charge_pkg::ADDR_STATUS) ||
                   (paddr == charge_pkg::ADDR_IRQ_STAT) || (paddr == charge_pkg::ADDR_IRQ_MASK);
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !hit;
  // set beats clear so no event is lost
  assign irq_clr = (apb_wr && paddr == charge_pkg::ADDR_IRQ_STAT) ? pwdata[3:0] : 4'h0;

  // register writes and sticky flags
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sw_en_reg    <= charge_pkg::CTRL_RESET_VAL[charge_pkg::CTRL_ENABLE_BIT];
      sw_vsel_reg  <= charge_pkg::CTRL_RESET_VAL[charge_pkg::CTRL_VSEL_BIT];
      irq_mask_reg <= charge_pkg::IRQ_MASK_RESET;
      irq_stat_reg <= 4'h0;
      temp_bad_reg <= 1'b0;
    end else begin
      temp_bad_reg <= !temp_ok;
      irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_evt;
      if (apb_wr && paddr == charge_pkg::ADDR_CTRL) begin
        sw_en_reg   <= pwdata[charge_pkg::CTRL_ENABLE_BIT];
        sw_vsel_reg <= pwdata[charge_pkg::CTRL_VSEL_BIT];
      end
      if (apb_wr && paddr == charge_pkg::ADDR_IRQ_MASK) begin
        irq_mask_reg <= pwdata[3:0];
      end
    end
  end

  // read mux, registered on the setup cycle
  logic [31:0] rd_next;
  assign rd_next = (paddr == charge_pkg::ADDR_CTRL)     ? {30'h0, sw_vsel_reg, sw_en_reg} :
                   (paddr == charge_pkg::ADDR_STATUS)   ? {22'h0, condition_indicator_in,
                                                           charge_indicator_in, vreg_reg,
                                                           !temp_ok, condition_indicator_out_reg, charge_indicator_out_reg, 1'b0,
                                                           phase_reg} :
                   (paddr == charge_pkg::ADDR_IRQ_STAT) ? {28'h0, irq_stat_reg} :
                   (paddr == charge_pkg::ADDR_IRQ_MASK) ? {28'h0, irq_mask_reg} :
                   32'h00000000;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable) begin
      prdata <= rd_next;
    end
  end

endmodule

// ==== verification/charge_checker_sva.sv ====
// concurrent checks on the charge supervisor ports
`timescale 1ns/10ps
module charge_checker (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // pins seen
  input wire logic supply_ok,
  input wire logic enable_in,
  input wire logic regulation_voltage_select,
  input wire logic cell_temp_sense_in,
  input wire logic cell_fault_in,
  input wire logic charge_on,
  input wire logic precon_mode,
  input wire logic cv_mode,
  input wire logic vreg_high,
  input wire logic low_power,
  input wire logic charge_indicator_out,
  input wire logic charge_indicator_oe,
  input wire logic condition_indicator_out,
  input wire logic condition_indicator_oe
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // =========================================================
  // held input conditions, three samples long to cover the register lag
  sequence s_temp_bad;
    !cell_temp_sense_in [*3];
  endsequence
  sequence s_unpowered;
    !supply_ok [*3];
  endsequence
  sequence s_disabled;
    !enable_in [*3];
  endsequence
  a_cond_when_ok:  assert property (charge_on [*2] |-> condition_indicator_oe)
    else $error("condition output off while charging");
  a_fault_stops:   assert property (charge_on && cell_fault_in |-> ##[1:2] !charge_on)
    else $error("charge kept on after fault");
  a_temp_holds:    assert property (s_temp_bad |-> !charge_on)
    else $error("charging with temperature out of window");
  a_vsel_high:     assert property (regulation_voltage_select [*2] |-> vreg_high)
    else $error("high target not selected");
  a_enable_off:    assert property (s_disabled |-> !charge_on && !charge_indicator_oe)
    else $error("charging while disabled");
  a_uvlo_halt:     assert property (s_unpowered |-> low_power && !charge_on)
    else $error("charging below lockout");
  a_mode_excl:     assert property (cv_mode |-> !precon_mode)
    else $error("precondition and voltage mode together");
  a_precon_led:    assert property ($rose(precon_mode) |-> ##[0:2] charge_indicator_oe)
    else $error("charge output off in precondition");
  a_od_low_level:  assert property (!charge_indicator_out && !condition_indicator_out)
    else $error("open-drain level not low");
endmodule

// ==== verification/status_pin_model.sv ====
// led and pull-up model on the two open-drain status pins
`timescale 1ns/10ps
module status_pin_model (
  // drive from the supervisor
  input  wire logic charge_indicator_out,
  input  wire logic charge_indicator_oe,
  input  wire logic condition_indicator_out,
  input  wire logic condition_indicator_oe,
  // resolved pin levels
  output logic      charge_indicator_in,
  output logic      condition_indicator_in
);
  // pull-up holds the line high whenever the pin is released
  assign charge_indicator_in    = charge_indicator_oe ? charge_indicator_out : 1'b1;
  assign condition_indicator_in = condition_indicator_oe ? condition_indicator_out : 1'b1;
endmodule

// ==== verification/tb_top.sv ====
// self-checking bench for the charge supervisor
`timescale 1ns/10ps
module tb_top;
  typedef struct {logic [31:0] v; logic [31:0] m;} note_s;
  logic clk_sys, rst, psel, penable, pwrite, pready, pslverr, irq, err_seen;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rnd;
  logic supply_ok, enable_in, regulation_voltage_select, cell_temp_sense_in;
  logic cell_above_precon, cell_at_regulation, current_below_term, cell_fault_in;
  logic charge_on, precon_mode, cv_mode, vreg_high, low_power;
  logic charge_indicator_in, charge_indicator_out, charge_indicator_oe;
  logic condition_indicator_in, condition_indicator_out, condition_indicator_oe;
  int err_count = 0;
  int num_checks = 0;
  note_s q[$];
  note_s nt;
  charge_state_supervisor charge_state_supervisor_i (.*);
  status_pin_model status_pin_model_i (.*);
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  // =========================================================
  // shared tasks
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // request held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    err_seen = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // a wait that runs out ends the run as a mismatch
    if (n >= 20) begin
      err_count++;
      give_verdict();
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
    q.push_back('{exp, m});
    apb(1'b0, a, 32'h0);
  endtask
  // read monitor takes the oldest note when a read completes
  always @(posedge clk_sys) begin
    if (psel && penable && pready && !pwrite) begin
      if (q.size() == 0) chk("read note", 32'h1, 32'h0);
      else begin
        nt = q.pop_front();
        chk("prdata", prdata & nt.m, nt.v);
      end
    end
  end
  // =========================================================
  // main sequence
  initial begin
    rnd = $urandom(97);
    rnd = $urandom;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {supply_ok, enable_in, cell_temp_sense_in, regulation_voltage_select} = 4'hE;
    {cell_above_precon, cell_at_regulation, current_below_term, cell_fault_in} = 4'h0;
    rst = 1'b1;
    step(10);
    rst <= 1'b0;
    apb(1'b1, charge_pkg::ADDR_CTRL, 32'h1);
    rd(charge_pkg::ADDR_CTRL, 32'h1, 32'h3);
    apb(1'b1, charge_pkg::ADDR_IRQ_MASK, {28'h0, rnd[3:0]});
    rd(charge_pkg::ADDR_IRQ_MASK, {28'h0, rnd[3:0]}, 32'hF);
    apb(1'b1, charge_pkg::ADDR_IRQ_MASK, 32'h0);
    rd(8'h10, 32'h0, 32'hFFFFFFFF);
    chk("pslverr", err_seen, 32'h1);
    $display("test registers done");
    // precondition, then current, temperature pause, voltage, done
    step(4);
    rd(charge_pkg::ADDR_STATUS, 32'h032, 32'h337);
    chk("precon_mode", precon_mode, 32'h1);
    for (int i = 0; i < 2; i++) begin
      regulation_voltage_select <= rnd[4] ^ i[0];
      step(4);
      chk("vreg_high", vreg_high, {31'h0, rnd[4] ^ i[0]});
    end
    cell_above_precon <= 1'b1;
    step(4);
    rd(charge_pkg::ADDR_STATUS, 32'h33, 32'h37);
    cell_temp_sense_in <= 1'b0;
    step(4);
    chk("charge_on", charge_on, 32'h0);
    rd(charge_pkg::ADDR_STATUS, 32'h43, 32'h47);
    cell_temp_sense_in <= 1'b1;
    step(4);
    chk("charge_on", charge_on, 32'h1);
    cell_at_regulation <= 1'b1;
    step(4);
    chk("cv_mode", cv_mode, 32'h1);
    rd(charge_pkg::ADDR_STATUS, 32'h4, 32'h7);
    current_below_term <= 1'b1;
    step(4);
    rd(charge_pkg::ADDR_STATUS, 32'h5, 32'h7);
    apb(1'b1, charge_pkg::ADDR_IRQ_MASK, 32'h1);
    step(2);
    chk("irq", irq, 32'h1);
    apb(1'b1, charge_pkg::ADDR_IRQ_STAT, 32'h1);
    step(2);
    chk("irq", irq, 32'h0);
    rd(charge_pkg::ADDR_IRQ_STAT, 32'h0, 32'h1);
    $display("test charge flow done");
    // disable, restart, fault latch and recovery
    enable_in <= 1'b0;
    {cell_above_precon, cell_at_regulation, current_below_term} <= 3'h0;
    step(4);
    chk("low_power", low_power, 32'h1);
    rd(charge_pkg::ADDR_STATUS, 32'h0, 32'h7);
    enable_in <= 1'b1;
    step(4);
    rd(charge_pkg::ADDR_STATUS, 32'h2, 32'h7);
    cell_fault_in <= 1'b1;
    step(4);
    chk("charge_indicator_oe", charge_indicator_oe, 32'h0);
    cell_fault_in <= 1'b0;
    step(4);
    rd(charge_pkg::ADDR_STATUS, 32'h6, 32'h7);
    enable_in <= 1'b0;
    step(2);
    enable_in <= 1'b1;
    step(4);
    rd(charge_pkg::ADDR_STATUS, 32'h2, 32'h7);
    $display("test fault done");
    // fault latched again, then a supply drop and return clears it
    cell_fault_in <= 1'b1;
    step(4);
    cell_fault_in <= 1'b0;
    rd(charge_pkg::ADDR_STATUS, 32'h6, 32'h7);
    supply_ok <= 1'b0;
    step(4);
    chk("low_power", low_power, 32'h1);
    chk("charge_on", charge_on, 32'h0);
    supply_ok <= 1'b1;
    step(4);
    rd(charge_pkg::ADDR_STATUS, 32'h2, 32'h7);
    $display("test lockout done");
    give_verdict();
  end
endmodule
// checker attached to the supervisor ports
bind charge_state_supervisor charge_checker charge_checker_i (.*);
